// File: inc/adc_ctrl_defs.vh
/*
 * Constants of the converter control block: register byte offsets,
 * field positions, reset values, state codes and conversion timing.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH

// Register byte offsets on the APB.
`define OFS_CONTROL_ZERO      8'h00
`define OFS_CONTROL_ONE       8'h04
`define OFS_PIN_ENABLE        8'h08
`define OFS_RESULT_LOW        8'h0C
`define OFS_RESULT_HIGH       8'h10
`define OFS_INT_CONTROL       8'h14

// Fields of converter_control_zero.
`define BIT_START             7
`define BIT_BUSY              6
`define BIT_POWER_OFF         5
`define BIT_INT_REF_CHAN      4
`define FLD_CHAN_HI           2
`define FLD_CHAN_LO           0

// Fields of converter_control_one.
`define BIT_BANDGAP_EN        6
`define BIT_DATA_FORMAT       5
`define BIT_REF_SELECT        4
`define FLD_DIV_HI            2
`define FLD_DIV_LO            0

// Fields of the interrupt control register.
`define BIT_GLOBAL_IE         0
`define BIT_ADC_IE            1
`define BIT_ADC_FLAG          2

// Reset values.
`define RST_BUSY              1'h1
`define RST_POWER_OFF         1'h1
`define RST_DIV_SEL           3'h0
`define RST_PIN_ENABLE        8'h00

// Conversion timing in conversion clock periods, and the first SAR trial code.
`define CONV_PERIODS          16
`define CONV_LAST_PERIOD      4'hF
`define SAR_FIRST_BIT_PERIOD  4'h1
`define SAR_LAST_BIT_PERIOD   4'hC
`define SAR_MSB               12'h800

// Converter sequencer states, one-hot.
`define ST_IDLE               3'h1
`define ST_HOLD               3'h2
`define ST_CONV               3'h4

`endif

// File: verilog/conv_clock_divider.v
/*
 * Conversion clock divider: one tick per conversion clock period,
 * derived from pclk by a power-of-two ratio chosen by a three-bit code.
 * Assumes the sequencer holds clear low while it needs ticks.
 */
`timescale 1ns/10ps
`include "adc_ctrl_defs.vh"

module conv_clock_divider #(
	parameter CNT_W = 6                     // Counter width, enough for divide by 64.
) (
	input  wire       pclk,                 // System clock.
	input  wire       presetn,              // Asynchronous reset, active low.
	input  wire       clear,                // Restart the period from zero.
	input  wire [2:0] div_sel,              // Divider select code.
	output reg        tick                  // One-cycle pulse at end of each period.
);

	reg  [CNT_W-1:0] cnt_q;
	wire [CNT_W-1:0] last_cnt;

	// Code 111 is undefined; it is run as divide by 64 so a conversion still ends.
	assign last_cnt = (div_sel == 3'h7) ? {CNT_W{1'b1}} :
		((({{(CNT_W-1){1'b0}}, 1'b1}) << div_sel) - {{(CNT_W-1){1'b0}}, 1'b1}); // [RULE1]

	// Count pclk cycles and pulse when the selected ratio is reached.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= {CNT_W{1'b0}};
			tick  <= 1'b0;
		end else if (clear) begin
			cnt_q <= {CNT_W{1'b0}};
			tick  <= 1'b0;
		end else if (cnt_q >= last_cnt) begin
			cnt_q <= {CNT_W{1'b0}};
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
			tick  <= 1'b0;
		end
	end

endmodule // conv_clock_divider

// File: verilog/adc_conversion_control.v
/*
 * Control logic of a 12-bit successive approximation converter: APB
 * registers, conversion clock divider, power and reference control,
 * analog pin enables, channel routing, start sequencing and interrupt.
 * Assumes an external analog DAC and comparator fed by sar_trial, and
 * port direction and pull-up settings arriving on the pclk domain.
 */
`timescale 1ns/10ps
`include "adc_ctrl_defs.vh"

// What this block does
// [RULE1] Conversion clock is pclk divided by 1,2,4..64 for codes 000..110; 111 undefined.
// [RULE2] Converter is powered only while adc_power_off is zero.
// [RULE3] Software waits a settling delay after power-on before any conversion.
// [RULE4] Software should set adc_power_off when the converter is unused.
// [RULE5] reference_select picks the external pin and disables its shared functions.
// [RULE6] An analog_pin_enable bit makes its pin analog and removes digital functions.
// [RULE7] Pull-ups are disconnected on pins selected as analog inputs.
// [RULE8] Analog pin selection overrides the port direction setting.
// [RULE9] channel_select routes input 0..7, or the internal reference when selected.
// [RULE10] Interrupt reaches the core only with both enables set.
// [RULE11] Software starts by raising then lowering the start bit, initially clear.
// [RULE12] Raising start resets the converter and sets busy until start falls.
// [RULE13] Busy falls at completion when result registers hold the new value.
// [RULE14] A conversion lasts sixteen conversion clock periods.
// [RULE15] The result is 12 bits with full scale all ones.
// [RULE16] Conversion runs autonomously without stalling the bus or processor.
// [RULE17] Software configures divider, power, channel, pins, interrupts, then starts.
// [RULE18] The request flag is set at every conversion end, enabled or not.
// [RULE19] Software keeps the conversion clock period above the permitted minimum.
// [RULE20] Results hold until the next completion and update with busy falling.
// [RULE21] Raising start mid-conversion aborts without result update or flag.
module adc_conversion_control (
	input  wire        pclk,              // System clock, 20 MHz.
	input  wire        presetn,           // Asynchronous reset, active low.
	input  wire        psel,              // APB select.
	input  wire        penable,           // APB access phase.
	input  wire        pwrite,            // APB write when high.
	input  wire [7:0]  paddr,             // APB byte address.
	input  wire [31:0] pwdata,            // APB write data.
	output wire        pready,            // APB ready.
	output wire [31:0] prdata,            // APB read data.
	output wire        pslverr,           // APB error on unmapped address.
	input  wire        comparator_in,     // Analog comparator, high when input >= DAC.
	input  wire [7:0]  port_dir_in,       // Port direction for the analog pins, 1 = input.
	input  wire [7:0]  pullup_cfg_in,     // Configured pull-ups for the analog pins.
	output wire        adc_powered,       // Converter analog power on.
	output wire        ref_from_pin,      // Reference taken from the external pin.
	output wire        ref_pin_shared_off,// Shared functions of the reference pin disabled.
	output wire        bandgap_enable,    // Internal 1.25 V bandgap on.
	output wire [8:0]  analog_route,      // One-hot input switch, bit 8 internal reference.
	output wire [7:0]  pin_analog_mode,   // Pin is analog, digital functions removed.
	output wire [7:0]  pin_dir_input,     // Effective direction, 1 = input.
	output wire [7:0]  pin_pullup_on,     // Effective pull-up connection.
	output wire        conv_reset,        // Converter held in reset.
	output wire        conv_sample,       // Sample phase of the conversion.
	output wire [11:0] sar_trial,         // Trial code to the DAC.
	output wire        adc_irq            // Interrupt request to the core.
);

	// Register fields.
	reg        start_q;
	reg        busy_q;
	reg        power_off_q;
	reg        int_ref_chan_q;
	reg [2:0]  chan_sel_q;
	reg        bandgap_en_q;
	reg        data_format_q;
	reg        ref_select_q;
	reg [2:0]  div_sel_q;
	reg [7:0]  pin_enable_q;
	reg        global_ie_q;
	reg        adc_ie_q;
	reg        adc_flag_q;
	reg [11:0] result_q;

	// APB answer registers.
	reg        pready_q;
	reg [31:0] prdata_q;
	reg        pslverr_q;
	reg [31:0] rd_data_d;
	reg        rd_err_d;

	// Sequencer and SAR.
	reg [2:0]  state_q;
	reg [2:0]  state_d;
	reg [3:0]  period_q;
	reg [11:0] trial_q;
	reg [11:0] trial_d;
	reg [11:0] bit_mask;
	reg        sample_q;
	reg        conv_done;

	// Comparator synchroniser and filtered decision.
	reg        cmp_s1_q;
	reg        cmp_s2_q;
	reg        cmp_s3_q;
	reg        cmp_q;

	// Pin and analog side outputs.
	reg        adc_powered_q;
	reg        ref_from_pin_q;
	reg [8:0]  analog_route_q;
	reg [7:0]  pin_dir_input_q;
	reg [7:0]  pin_pullup_on_q;
	reg        adc_irq_q;

	wire       access;
	wire       wr;
	wire       wr_ctrl0;
	wire       start_new;
	wire       start_rise;
	wire       start_fall;
	wire       tick;
	reg        conv_reset_q;

	// Result byte placement under the data format bit.
	function [7:0] result_byte;
		input        high;
		input        fmt;
		input [11:0] r;
		begin
			if (fmt)
				result_byte = high ? {4'h0, r[11:8]} : r[7:0];
			else
				result_byte = high ? r[11:4] : {r[3:0], 4'h0};
		end
	endfunction

	// Each access waits exactly one cycle; read data are latched on the edge that raises pready, write data on the next edge.
	// The converter never stretches a transfer, so software keeps running. [RULE16]
	assign access    = psel & penable & pready_q;
	assign wr        = access & pwrite;
	assign wr_ctrl0  = wr & (paddr == `OFS_CONTROL_ZERO);
	assign start_new = pwdata[`BIT_START];
	assign start_rise = wr_ctrl0 & ~start_q & start_new;
	assign start_fall = wr_ctrl0 & start_q & ~start_new;

	// Read decode for the first access cycle.
	always @* begin
		rd_data_d = 32'h0000_0000;
		rd_err_d  = 1'b0;
		case (paddr)
			`OFS_CONTROL_ZERO: begin
				rd_data_d[`BIT_START]        = start_q;
				rd_data_d[`BIT_BUSY]         = busy_q;
				rd_data_d[`BIT_POWER_OFF]    = power_off_q;
				rd_data_d[`BIT_INT_REF_CHAN] = int_ref_chan_q;
				rd_data_d[`FLD_CHAN_HI:`FLD_CHAN_LO] = chan_sel_q;
			end
			`OFS_CONTROL_ONE: begin
				rd_data_d[`BIT_BANDGAP_EN]   = bandgap_en_q;
				rd_data_d[`BIT_DATA_FORMAT]  = data_format_q;
				rd_data_d[`BIT_REF_SELECT]   = ref_select_q;
				rd_data_d[`FLD_DIV_HI:`FLD_DIV_LO] = div_sel_q;
			end
			`OFS_PIN_ENABLE:  rd_data_d[7:0] = pin_enable_q;
			`OFS_RESULT_LOW:  rd_data_d[7:0] = result_byte(1'b0, data_format_q, result_q);
			`OFS_RESULT_HIGH: rd_data_d[7:0] = result_byte(1'b1, data_format_q, result_q);
			`OFS_INT_CONTROL: begin
				rd_data_d[`BIT_GLOBAL_IE] = global_ie_q;
				rd_data_d[`BIT_ADC_IE]    = adc_ie_q;
				rd_data_d[`BIT_ADC_FLAG]  = adc_flag_q;
			end
			default: rd_err_d = 1'b1;
		endcase
	end

	// APB answer: pready rises in the second access cycle with data and error.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= psel & penable & ~pready_q;
			if (psel & penable & ~pready_q) begin
				prdata_q  <= pwrite ? 32'h0000_0000 : rd_data_d;
				pslverr_q <= rd_err_d;
			end else begin
				prdata_q  <= 32'h0000_0000;
				pslverr_q <= 1'b0;
			end
		end
	end

	// Software writable control fields; busy and results are read-only.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_q        <= 1'b0;
			power_off_q    <= `RST_POWER_OFF;
			int_ref_chan_q <= 1'b0;
			chan_sel_q     <= 3'h0;
			bandgap_en_q   <= 1'b0;
			data_format_q  <= 1'b0;
			ref_select_q   <= 1'b0;
			div_sel_q      <= `RST_DIV_SEL;
			pin_enable_q   <= `RST_PIN_ENABLE;
			global_ie_q    <= 1'b0;
			adc_ie_q       <= 1'b0;
		end else if (wr) begin
			case (paddr)
				`OFS_CONTROL_ZERO: begin
					start_q        <= start_new;
					power_off_q    <= pwdata[`BIT_POWER_OFF];
					int_ref_chan_q <= pwdata[`BIT_INT_REF_CHAN];
					chan_sel_q     <= pwdata[`FLD_CHAN_HI:`FLD_CHAN_LO];
				end
				`OFS_CONTROL_ONE: begin
					bandgap_en_q  <= pwdata[`BIT_BANDGAP_EN];
					data_format_q <= pwdata[`BIT_DATA_FORMAT];
					ref_select_q  <= pwdata[`BIT_REF_SELECT];
					div_sel_q     <= pwdata[`FLD_DIV_HI:`FLD_DIV_LO];
				end
				`OFS_PIN_ENABLE:  pin_enable_q <= pwdata[7:0];
				`OFS_INT_CONTROL: begin
					global_ie_q <= pwdata[`BIT_GLOBAL_IE];
					adc_ie_q    <= pwdata[`BIT_ADC_IE];
				end
				default: ;
			endcase
		end
	end

	// Conversion clock ticks only while converting, so period zero is aligned to the start.
	conv_clock_divider #(
		.CNT_W   (6)
	) u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.clear   (conv_reset_q),
		.div_sel (div_sel_q),
		.tick    (tick)
	);

	// Comparator crosses from the analog domain; the decision moves only when
	// stages two and three agree, which filters a single-cycle glitch.
	// Limitation: the decision lags the DAC by four cycles, too late for the next tick below divide by 8.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_s1_q <= 1'b0;
			cmp_s2_q <= 1'b0;
			cmp_s3_q <= 1'b0;
			cmp_q    <= 1'b0;
		end else begin
			cmp_s1_q <= comparator_in;
			cmp_s2_q <= cmp_s1_q;
			cmp_s3_q <= cmp_s2_q;
			if (cmp_s2_q == cmp_s3_q)
				cmp_q <= cmp_s3_q;
		end
	end

	// Sequencer next state: a start rise always wins and holds the converter.
	always @* begin
		state_d   = state_q;
		conv_done = 1'b0;
		case (state_q)
			`ST_IDLE: begin
				if (start_rise)
					state_d = `ST_HOLD;                            // [RULE12]
			end
			`ST_HOLD: begin
				if (start_fall)
					state_d = power_off_q ? `ST_IDLE : `ST_CONV;   // [RULE11]
			end
			`ST_CONV: begin
				if (start_rise)
					state_d = `ST_HOLD;                            // [RULE21]
				else if (power_off_q)
					state_d = `ST_IDLE;                            // [RULE2]
				else if (tick && (period_q == `CONV_LAST_PERIOD)) begin
					state_d   = `ST_IDLE;                          // [RULE14]
					conv_done = 1'b1;
				end
			end
			default: state_d = `ST_IDLE;
		endcase
	end

	// Successive approximation: period 0 samples, periods 1..12 resolve one bit
	// each from the MSB, so codes run from zero up to all ones. [RULE15]
	always @* begin
		bit_mask = `SAR_MSB >> (period_q - `SAR_FIRST_BIT_PERIOD);
		trial_d  = trial_q;
		if (tick) begin
			if (period_q == 4'h0)
				trial_d = `SAR_MSB;
			else if ((period_q >= `SAR_FIRST_BIT_PERIOD) && (period_q <= `SAR_LAST_BIT_PERIOD))
				trial_d = (trial_q & ~(bit_mask & {12{~cmp_q}})) | (bit_mask >> 1);
		end
	end

	// Sequencer registers, period count and trial code.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q  <= `ST_IDLE;
			period_q <= 4'h0;
			trial_q  <= 12'h000;
			sample_q <= 1'b0;
			conv_reset_q <= 1'b1;
		end else begin
			state_q <= state_d;
			conv_reset_q <= (state_d != `ST_CONV); // Own flop keeps the reset pin glitch free. [RULE12]
			if (state_d != `ST_CONV || state_q != `ST_CONV) begin
				period_q <= 4'h0;
				trial_q  <= 12'h000;
				sample_q <= (state_d == `ST_CONV);
			end else begin
				if (tick)
					period_q <= period_q + 4'h1;               // [RULE14]
				trial_q  <= trial_d;
				if (tick && period_q == 4'h0)
					sample_q <= 1'b0;
			end
		end
	end

	// Busy, result and request flag; the flag set wins over a software clear.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q     <= `RST_BUSY;
			result_q   <= 12'h000;
			adc_flag_q <= 1'b0;
		end else begin
			if (start_rise)
				busy_q <= 1'b1;                                   // [RULE12]
			else if (conv_done)
				busy_q <= 1'b0;                                   // [RULE13]
			if (conv_done)
				result_q <= trial_q;                              // [RULE20]
			if (conv_done)
				adc_flag_q <= 1'b1;                               // [RULE18]
			else if (wr && paddr == `OFS_INT_CONTROL && !pwdata[`BIT_ADC_FLAG])
				adc_flag_q <= 1'b0;
		end
	end

	// Analog side controls, registered so every output comes from a flop.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_powered_q   <= 1'b0;
			ref_from_pin_q  <= 1'b0;
			analog_route_q  <= 9'h000;
			pin_dir_input_q <= 8'h00;
			pin_pullup_on_q <= 8'h00;
			adc_irq_q       <= 1'b0;
		end else begin
			adc_powered_q   <= ~power_off_q;                             // [RULE2]
			ref_from_pin_q  <= ref_select_q;                             // [RULE5]
			analog_route_q  <= int_ref_chan_q ? 9'h100 :
				{1'b0, 8'h01 << chan_sel_q};                             // [RULE9]
			pin_dir_input_q <= port_dir_in | pin_enable_q;               // [RULE8]
			pin_pullup_on_q <= pullup_cfg_in & ~pin_enable_q;            // [RULE7]
			adc_irq_q       <= adc_flag_q & global_ie_q & adc_ie_q;      // [RULE10]
		end
	end

	// Outputs straight from registers.
	assign pready             = pready_q;
	assign prdata             = prdata_q;
	assign pslverr            = pslverr_q;
	assign adc_powered        = adc_powered_q;
	assign ref_from_pin       = ref_from_pin_q;
	assign ref_pin_shared_off = ref_from_pin_q;                      // [RULE5]
	assign bandgap_enable     = bandgap_en_q;
	assign analog_route       = analog_route_q;
	assign pin_analog_mode    = pin_enable_q;                        // [RULE6]
	assign pin_dir_input      = pin_dir_input_q;
	assign pin_pullup_on      = pin_pullup_on_q;
	assign conv_reset         = conv_reset_q;                        // [RULE12]
	assign conv_sample        = sample_q;
	assign sar_trial          = trial_q;
	assign adc_irq            = adc_irq_q;

endmodule // adc_conversion_control

// File: verif/adc_ctrl_chk.sv
/* Assertions on the ports of the converter control block.
   Assumes one pclk domain and the one-wait-state APB slave. */
`timescale 1ns/10ps
module adc_ctrl_chk (
	input wire logic        pclk,               // Clock.
	input wire logic        presetn,            // Reset, active low.
	input wire logic        psel,               // APB select.
	input wire logic        penable,            // APB enable.
	input wire logic        pwrite,             // APB write.
	input wire logic [7:0]  paddr,              // APB address.
	input wire logic [31:0] pwdata,             // APB write data.
	input wire logic        pready,             // APB ready.
	input wire logic [7:0]  port_dir_in,        // Port direction.
	input wire logic [7:0]  pullup_cfg_in,      // Pull-up setting.
	input wire logic        adc_powered,        // Analog power.
	input wire logic        ref_from_pin,       // External reference.
	input wire logic        ref_pin_shared_off, // Reference pin shared functions off.
	input wire logic [8:0]  analog_route,       // Input switch.
	input wire logic [7:0]  pin_analog_mode,    // Analog pins.
	input wire logic [7:0]  pin_dir_input,      // Effective direction.
	input wire logic [7:0]  pin_pullup_on,      // Effective pull-ups.
	input wire logic        conv_reset,         // Converter reset.
	input wire logic        conv_sample         // Sample phase.
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Accepted writes, decoded per register.
	wire acc = psel & penable & pready & pwrite;
	wire wr0 = acc && paddr == 8'h00;
	logic [2:0]  div_q;
	logic [10:0] cnt_q;
	wire  [10:0] cnt_d = conv_reset ? 11'h000 : cnt_q + 11'h001;
	// Track the divider code and the length of each conversion.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 3'h0;
			cnt_q <= 11'h000;
		end else begin
			if (acc && paddr == 8'h04) div_q <= pwdata[2:0];
			cnt_q <= cnt_d;
		end
	end
	sequence s_setup; psel && !penable; endsequence
	sequence s_wait; !pready ##1 pready; endsequence
	property p_ready; s_setup |=> s_wait; endproperty
	a_ready: assert property (p_ready) else $error("ready not in second access cycle");
	property p_power; wr0 |-> ##2 adc_powered == !$past(pwdata[5], 2); endproperty
	a_power: assert property (p_power) else $error("power does not follow its bit");
	property p_route;
		wr0 |-> ##2 analog_route == ($past(pwdata[4], 2) ? 9'h100 : 9'h001 << $past(pwdata[2:0], 2));
	endproperty
	a_route: assert property (p_route) else $error("input switch wrong");
	property p_ref;
		acc && paddr == 8'h04 |-> ##2 ref_from_pin == $past(pwdata[4], 2) && ref_pin_shared_off == ref_from_pin;
	endproperty
	a_ref: assert property (p_ref) else $error("reference select wrong");
	property p_mode; acc && paddr == 8'h08 |=> pin_analog_mode == $past(pwdata[7:0]); endproperty
	a_mode: assert property (p_mode) else $error("analog pin mode wrong");
	property p_dir; $past(presetn) |-> pin_dir_input == ($past(port_dir_in) | $past(pin_analog_mode)); endproperty
	a_dir: assert property (p_dir) else $error("direction not overridden");
	property p_pull; $past(presetn) |-> pin_pullup_on == ($past(pullup_cfg_in) & ~$past(pin_analog_mode)); endproperty
	a_pull: assert property (p_pull) else $error("pull-up not removed");
	property p_start; $fell(conv_reset) |-> $past(wr0 && !pwdata[7] && !pwdata[5]); endproperty
	a_start: assert property (p_start) else $error("conversion began without start fall");
	property p_sample; $fell(conv_reset) |-> ##[0:1] conv_sample; endproperty
	a_sample: assert property (p_sample) else $error("no sample phase");
	property p_len;
		$rose(conv_reset) && !$past(wr0) |-> cnt_q >= (16 << div_q) - 1 && cnt_q <= (16 << div_q) + 3;
	endproperty
	a_len: assert property (p_len) else $error("conversion length wrong");
endmodule // adc_ctrl_chk

bind adc_conversion_control adc_ctrl_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .port_dir_in(port_dir_in),
	.pullup_cfg_in(pullup_cfg_in), .adc_powered(adc_powered), .ref_from_pin(ref_from_pin),
	.ref_pin_shared_off(ref_pin_shared_off), .analog_route(analog_route), .pin_analog_mode(pin_analog_mode),
	.pin_dir_input(pin_dir_input), .pin_pullup_on(pin_pullup_on), .conv_reset(conv_reset),
	.conv_sample(conv_sample));

// File: verif/analog_front_model.sv
/* Analog side: eight pin levels, the bandgap, and a comparator against the trial code.
   Assumes the bench sets the pin levels as codes. */
`timescale 1ns/10ps
module analog_front_model #(
	parameter logic [11:0] REF_CODE = 12'h4E2 // Bandgap code, value arbitrary.
) (
	input  wire logic [95:0] levels,       // Pin levels, 12 bits each.
	input  wire logic [8:0]  analog_route, // Input switch.
	input  wire logic        adc_powered,  // Analog power.
	input  wire logic [11:0] sar_trial,    // Trial code.
	output logic             comparator_in // Input at or above trial.
);
	logic [11:0] sel;
	// An open switch reads as ground, so a wrong route shows in the result.
	always @* begin
		sel = 12'h000;
		for (int i = 0; i < 8; i++) if (analog_route[i]) sel = levels[i*12 +: 12];
		if (analog_route[8]) sel = REF_CODE;
		comparator_in = adc_powered && sel >= sar_trial;
	end
endmodule // analog_front_model

// File: verif/tb_adc_conversion_control.sv
/* Self-checking bench of the converter control block over APB.
   Assumes the analog model in its own file and the bound checker. */
`timescale 1ns/10ps
module tb_adc_conversion_control;
	localparam logic [11:0] REF_CODE = 12'h4E2; // Bandgap code, value arbitrary.
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, serr;
	logic [7:0]  paddr = 8'h00, port_dir_in = 8'h00, pullup_cfg_in = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	logic [95:0] levels = 96'h0;
	wire         pready, pslverr, comparator_in, adc_powered, ref_from_pin, ref_pin_shared_off;
	wire         bandgap_enable, conv_reset, conv_sample, adc_irq;
	wire [31:0]  prdata;
	wire [8:0]   analog_route;
	wire [7:0]   pin_analog_mode, pin_dir_input, pin_pullup_on;
	wire [11:0]  sar_trial;
	int          err_count = 0, n_compared = 0;
	adc_conversion_control uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.comparator_in(comparator_in), .port_dir_in(port_dir_in), .pullup_cfg_in(pullup_cfg_in),
		.adc_powered(adc_powered), .ref_from_pin(ref_from_pin), .ref_pin_shared_off(ref_pin_shared_off),
		.bandgap_enable(bandgap_enable), .analog_route(analog_route), .pin_analog_mode(pin_analog_mode),
		.pin_dir_input(pin_dir_input), .pin_pullup_on(pin_pullup_on), .conv_reset(conv_reset),
		.conv_sample(conv_sample), .sar_trial(sar_trial), .adc_irq(adc_irq));
	analog_front_model #(.REF_CODE(REF_CODE)) front (.levels(levels), .analog_route(analog_route),
		.adc_powered(adc_powered), .sar_trial(sar_trial), .comparator_in(comparator_in));
	// 20 MHz clock.
	always #25 pclk = ~pclk;
	function logic [11:0] lvl(input int i);
		return (i == 7) ? 12'hFFF : 12'h05A + 12'(i) * 12'h211;
	endfunction
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One APB transfer; the request stands until pready is sampled high.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1 && ++n < 20);
		if (pready !== 1'h1) err_count++; // A missing answer counts as a mismatch.
		rd = prdata;
		serr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Start pulse, then poll busy; polling proves the bus stays usable meanwhile.
	task convert(input logic [7:0] c0);
		int n;
		n = 0;
		apb(1, 8'h00, {24'h0, c0 | 8'h80});
		apb(0, 8'h00, 32'h0);
		chk("busy_after_rise", rd[6], 1);
		apb(1, 8'h00, {24'h0, c0});
		do apb(0, 8'h00, 32'h0); while (rd[6] !== 1'h0 && ++n < 500);
		chk("busy_done", rd[6], 0);
	endtask
	task check_result(input logic [11:0] r, input logic fmt);
		apb(0, 8'h10, 32'h0);
		chk("result_high", rd, fmt ? {28'h0, r[11:8]} : {24'h0, r[11:4]});
		apb(0, 8'h0C, 32'h0);
		chk("result_low", rd, fmt ? {24'h0, r[7:0]} : {24'h0, r[3:0], 4'h0});
	endtask
	task summarize;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Watchdog, well beyond the roughly 7000 cycles the tests need.
	initial begin
		#(50 * 30000);
		err_count++;
		summarize;
	end
	// Main sequence.
	initial begin
		for (int i = 0; i < 8; i++) levels[i*12 +: 12] = lvl(i);
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		port_dir_in <= 8'h0F;
		pullup_cfg_in <= 8'hFF;
		apb(0, 8'h00, 32'h0);
		chk("ctrl0_reset", rd, 32'h60);
		apb(0, 8'h04, 32'h0);
		chk("ctrl1_reset", rd, 32'h0);
		apb(1, 8'h18, 32'hFF);
		chk("unmapped_err", serr, 1);
		apb(1, 8'h08, 32'hA5);
		repeat (3) @(posedge pclk);
		chk("pin_mode", pin_analog_mode, 8'hA5);
		chk("pin_dir", pin_dir_input, 8'hAF);
		chk("pin_pullup", pin_pullup_on, 8'h5A);
		apb(1, 8'h04, 32'h54); // Divide by 16 keeps the period above the minimum.
		apb(1, 8'h00, 32'h0); // Power on only after the divider is set.
		repeat (3) @(posedge pclk);
		chk("ref_pin", {ref_from_pin, ref_pin_shared_off}, 2'h3);
		chk("powered", adc_powered, 1);
		chk("bandgap", bandgap_enable, 1);
		repeat (40) @(posedge pclk); // Settling time before the first start.
		$display("test setup done");
		// All eight channels and the bandgap, alternating result formats.
		for (int i = 0; i < 9; i++) begin
			apb(1, 8'h04, 32'h54 | {i[0], 5'h0});
			convert(i < 8 ? 8'(i) : 8'h10);
			check_result(i < 8 ? lvl(i) : REF_CODE, i[0]);
			apb(0, 8'h14, 32'h0);
			chk("flag", rd[2], 1);
			chk("irq_masked", adc_irq, 0);
			apb(1, 8'h14, 32'h0);
		end
		$display("test channels done");
		// Every combination of the two enables.
		for (int e = 0; e < 4; e++) begin
			apb(1, 8'h14, 32'(e));
			convert(8'h03);
			repeat (3) @(posedge pclk);
			chk("irq", adc_irq, e == 3);
		end
		apb(1, 8'h14, 32'h3);
		repeat (3) @(posedge pclk);
		chk("irq_cleared", adc_irq, 0);
		apb(1, 8'h14, 32'h0);
		$display("test interrupt done");
		// A second start rise in mid-conversion leaves the old result.
		convert(8'h02);
		apb(1, 8'h14, 32'h0); // Clear the flag so only the aborted run could set it.
		levels[24 +: 12] <= 12'h333;
		apb(1, 8'h00, 32'h82);
		apb(1, 8'h00, 32'h02);
		repeat (100) @(posedge pclk);
		apb(1, 8'h00, 32'h82);
		repeat (300) @(posedge pclk);
		apb(0, 8'h00, 32'h0);
		chk("abort_busy", rd[6], 1);
		check_result(lvl(2), 0);
		apb(0, 8'h14, 32'h0);
		chk("abort_flag", rd[2], 0);
		convert(8'h02);
		check_result(12'h333, 0);
		$display("test abort done");
		// Slower divider codes; the checker measures the length.
		for (int d = 5; d < 7; d++) begin
			apb(1, 8'h04, 32'h50 | 32'(d));
			convert(8'h05);
			check_result(lvl(5), 0);
		end
		// Power off refuses a start pulse.
		apb(1, 8'h00, 32'hA0);
		apb(1, 8'h00, 32'h20);
		repeat (400) @(posedge pclk);
		apb(0, 8'h00, 32'h0);
		chk("off_busy", rd[6], 1);
		chk("off_power", adc_powered, 0);
		$display("test divider and power done");
		summarize;
	end
endmodule // tb_adc_conversion_control
